// ==== cmr_params.svh ====
// Purpose: Constants of the chip mode, reset and pin configuration block.
// Assumes: Included by the block's package users by bare name.
// Notes:   Offsets are byte addresses in the 64K address space.
`ifndef CMR_PARAMS_SVH
`define CMR_PARAMS_SVH

// On-chip I/O occupies the top 1K bytes.
`define CMR_IO_BASE        16'hFC00
// On-chip RAM begins here and extends downward.
`define CMR_RAM_TOP        16'hFBFF
`define CMR_ROM_BYTES      4096
`define CMR_RAM_BYTES      256

// Time base and instruction clock rates, in MHz.
`define CMR_TIME_BASE_MHZ  12
`define CMR_INSTR_MHZ      6
// Time-base cycles per half period of the instruction clock.
`define CMR_CLK_HALF       1

// Control bit positions inside the upper half of port one.
`define CMR_CTL_ADDR_STB   0
`define CMR_CTL_DATA_STB   1
`define CMR_CTL_READ       2
`define CMR_CTL_ACK        3
`define CMR_CTL_REQ        4
`define CMR_CTL_GNT        5

`endif

// ==== cmr_pkg.sv ====
// Purpose: Types of the chip mode, reset and pin configuration block.
// Assumes: Widths of the ports are fixed at 16 and 8 bits.
// Notes:   All block state lives in one packed struct.
package cmr_pkg;

    typedef enum logic [3:0] {
        CMR_M_HOLD  = 4'h1,
        CMR_M_SAMP0 = 4'h2,
        CMR_M_SAMP1 = 4'h4,
        CMR_M_RUN   = 4'h8
    } cmr_mst_t;

    typedef enum logic [1:0] {
        CMR_SINGLE  = 2'h0,
        CMR_PARTIAL = 2'h1,
        CMR_FULL    = 2'h2
    } cmr_mode_t;

    typedef enum logic [3:0] {
        CMR_B_IDLE = 4'h1,
        CMR_B_REQ  = 4'h2,
        CMR_B_ADDR = 4'h4,
        CMR_B_DATA = 4'h8
    } cmr_bst_t;

    typedef enum logic [1:0] {
        CMR_HS_GPIO  = 2'h0,
        CMR_HS_IN    = 2'h1,
        CMR_HS_OUT   = 2'h2,
        CMR_HS_BIDIR = 2'h3
    } cmr_hs_t;

    typedef enum logic {
        CMR_BUS_PROC = 1'b0,
        CMR_BUS_GP   = 1'b1
    } cmr_bus_t;

    typedef struct packed {
        cmr_mst_t    mst;
        cmr_mode_t   mode;
        logic        strap0;
        logic        clk;
        logic        core_rst;
        logic        nmi_prev;
        logic        nmi_pend;
        logic        irq_take;
        logic [3:0]  irq_vec;
        cmr_bst_t    bst;
        logic        req;
        logic        gnt;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        we;
        logic [15:0] rdata;
        logic        done;
        logic        internal;
        logic        err;
        logic [15:0] p0_out;
        logic [15:0] p0_oe_n;
        logic [7:0]  p1_out;
        logic [7:0]  p1_oe_n;
        logic [15:0] p0_rd;
        logic [7:0]  p1_rd;
        logic [1:0]  strb_prev;
        logic [1:0]  in_full;
        logic [1:0]  out_full;
        logic [1:0]  ready;
        logic [15:0] hs_in;
    } cmr_state_t;

endpackage

// ==== cmr_chip_config.sv ====
// Purpose: Chip mode, reset, clock output and pin configuration logic.
// Assumes: sys_clk_in is the time base; all pins are synchronous to it.
// Notes:   The processor core sits outside and uses the core-side ports.
`timescale 1ns/1ps
`include "cmr_params.svh"

module cmr_chip_config
    import cmr_pkg::*;
#(
    parameter cmr_bus_t BUS_VARIANT = CMR_BUS_GP,
    parameter bit       EXECUTIVE   = 1'b1,
    parameter int       ROM_BYTES   = `CMR_ROM_BYTES,
    parameter int       RAM_BYTES   = `CMR_RAM_BYTES
) (
    input  wire logic        sys_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        chip_reset_n_in,
    input  wire logic        mode_strap_in,
    input  wire logic        nmi_n_in,
    input  wire logic        nmi_ack_in,
    input  wire logic        level_one_irq_enable_in,
    input  wire logic [15:0] irq_req_in,
    input  wire logic [15:0] gpio0_out_in,
    input  wire logic [15:0] gpio0_dir_in,
    input  wire logic [7:0]  gpio1_hi_out_in,
    input  wire logic [7:0]  gpio1_hi_dir_in,
    input  wire logic [3:0]  hs_mode_in,
    input  wire logic [1:0]  hs_write_in,
    input  wire logic [1:0]  hs_read_in,
    input  wire logic [1:0]  strobe_in,
    input  wire logic        acc_req_in,
    input  wire logic        acc_we_in,
    input  wire logic [15:0] acc_addr_in,
    input  wire logic [15:0] acc_wdata_in,
    input  wire logic [15:0] parallel_port_zero_in,
    input  wire logic [7:0]  port_one_hi_in,
    output logic             core_reset_out,
    output logic             instruction_clock_out,
    output cmr_mode_t        bus_mode_out,
    output logic             nmi_take_out,
    output logic             irq_take_out,
    output logic [3:0]       irq_vector_out,
    output logic [15:0]      gpio0_rd_out,
    output logic [7:0]       gpio1_hi_rd_out,
    output logic [1:0]       ready_out,
    output logic [15:0]      hs_data_out,
    output logic             acc_done_out,
    output logic             acc_internal_out,
    output logic             acc_err_out,
    output logic [15:0]      acc_rdata_out,
    output logic [15:0]      parallel_port_zero_out,
    output logic [15:0]      parallel_port_zero_oe_n_out,
    output logic [7:0]       port_one_hi_out,
    output logic [7:0]       port_one_hi_oe_n_out
);

    localparam logic [16:0] ROM_LIM = 17'(ROM_BYTES);
    localparam logic [15:0] RAM_LO  = 16'(`CMR_RAM_TOP - RAM_BYTES + 1);
    // The processor-compatible variant is always a bus peripheral.
    localparam bit IS_EXEC = (BUS_VARIANT == CMR_BUS_GP) && EXECUTIVE;

    cmr_state_t s_q;
    cmr_state_t s_d;
    logic       rst;

    // Served on chip: I/O page, RAM below it, ROM from zero except in full mode.
    function automatic logic on_chip(input logic [15:0] a,
                                     input cmr_mode_t m);
        logic io;
        logic ram;
        logic rom;
        io  = (a >= `CMR_IO_BASE);
        ram = (a <= `CMR_RAM_TOP) && (a >= RAM_LO);
        rom = (m != CMR_FULL) && ({1'b0, a} < ROM_LIM);
        return io | ram | rom;
    endfunction

    // Control lines other than the read line are active low on the processor-compatible variant.
    function automatic logic ctl(input logic a);
        return (BUS_VARIANT == CMR_BUS_PROC) ? ~a : a;
    endfunction

    // Lowest numbered pending request wins.
    function automatic logic [3:0] prio(input logic [15:0] r);
        logic [3:0] v;
        v = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (r[i]) begin
                v = 4'(i);
            end
        end
        return v;
    endfunction

    assign rst = sys_rst_in | ~chip_reset_n_in;

    always_comb begin
        logic        expd;
        logic        fall;
        logic        sf;
        logic        sr;
        logic        ack;
        logic        ext_req;
        logic [15:0] en;
        cmr_hs_t     hm;
        expd    = 1'b0;
        fall    = 1'b0;
        sf      = 1'b0;
        sr      = 1'b0;
        ack     = 1'b0;
        ext_req = 1'b0;
        en      = 16'h0000;
        hm      = CMR_HS_GPIO;
        s_d = s_q;
        s_d.done     = 1'b0;
        s_d.internal = 1'b0;
        s_d.err      = 1'b0;
        s_d.clk      = ~s_q.clk;

        case (s_q.mst)
            CMR_M_HOLD: begin
                s_d.mst = CMR_M_SAMP0;
            end
            CMR_M_SAMP0: begin
                s_d.strap0 = mode_strap_in;
                s_d.mst    = CMR_M_SAMP1;
            end
            CMR_M_SAMP1: begin
                // A strap that followed the clock output toggled between
                // the two samples.
                if (s_q.strap0 != mode_strap_in) begin
                    s_d.mode = CMR_FULL;
                end else if (mode_strap_in) begin
                    s_d.mode = CMR_SINGLE;
                end else begin
                    s_d.mode = CMR_PARTIAL;
                end
                s_d.mst = CMR_M_RUN;
            end
            CMR_M_RUN: begin
                s_d.mst = CMR_M_RUN;
            end
            default: begin
                s_d.mst = CMR_M_HOLD;
            end
        endcase
        s_d.core_rst = (s_d.mst != CMR_M_RUN);

        fall         = s_q.nmi_prev & ~nmi_n_in;
        s_d.nmi_prev = nmi_n_in;
        if (nmi_ack_in) begin
            s_d.nmi_pend = 1'b0;
        end
        if (fall) begin
            s_d.nmi_pend = 1'b1;
        end
        en = irq_req_in & {16{level_one_irq_enable_in}};
        s_d.irq_take = (|en) & ~s_d.nmi_pend;
        s_d.irq_vec  = prio(en);
        if (s_q.core_rst) begin
            s_d.nmi_pend = 1'b0;
            s_d.irq_take = 1'b0;
        end

        expd      = (s_q.mode != CMR_SINGLE);
        s_d.p0_rd = parallel_port_zero_in;
        s_d.p1_rd = port_one_hi_in;
        ack       = ctl(port_one_hi_in[`CMR_CTL_ACK]);
        ext_req   = ctl(port_one_hi_in[`CMR_CTL_REQ]);

        s_d.p0_out  = gpio0_out_in;
        s_d.p0_oe_n = ~gpio0_dir_in;
        for (int b = 0; b < 2; b++) begin
            hm = cmr_hs_t'(hs_mode_in[2*b +: 2]);
            sf = s_q.strb_prev[b] & ~strobe_in[b];
            sr = ~s_q.strb_prev[b] & strobe_in[b];
            s_d.strb_prev[b] = strobe_in[b];
            s_d.ready[b]     = 1'b0;
            case (hm)
                CMR_HS_IN: begin
                    if (hs_read_in[b]) begin
                        s_d.in_full[b] = 1'b0;
                    end
                    if (sf && !s_q.in_full[b]) begin
                        s_d.hs_in[8*b +: 8] = parallel_port_zero_in[8*b +: 8];
                        s_d.in_full[b] = 1'b1;
                    end
                    s_d.p0_oe_n[8*b +: 8] = 8'hFF;
                    s_d.ready[b] = ~s_d.in_full[b];
                end
                CMR_HS_OUT: begin
                    if (sr) begin
                        s_d.out_full[b] = 1'b0;
                    end
                    if (hs_write_in[b]) begin
                        s_d.out_full[b] = 1'b1;
                    end
                    s_d.p0_oe_n[8*b +: 8] = 8'h00;
                    s_d.ready[b] = s_d.out_full[b];
                end
                CMR_HS_BIDIR: begin
                    // Latch on the rising strobe, before our drive starts.
                    if (sr) begin
                        s_d.hs_in[8*b +: 8] = parallel_port_zero_in[8*b +: 8];
                    end
                    if (sf) begin
                        s_d.out_full[b] = 1'b0;
                    end
                    if (hs_write_in[b]) begin
                        s_d.out_full[b] = 1'b1;
                    end
                    s_d.p0_oe_n[8*b +: 8] = {8{~strobe_in[b]}};
                    s_d.ready[b] = s_d.out_full[b];
                end
                default: begin
                    s_d.in_full[b]  = 1'b0;
                    s_d.out_full[b] = 1'b0;
                end
            endcase
        end
        s_d.p1_out  = gpio1_hi_out_in;
        s_d.p1_oe_n = ~gpio1_hi_dir_in;

        // An executive hands the bus over only while it is idle.
        if (IS_EXEC) begin
            s_d.gnt = expd && ext_req &&
                      (s_q.gnt || (s_q.bst == CMR_B_IDLE));
        end else begin
            s_d.gnt = 1'b0;
        end

        case (s_q.bst)
            CMR_B_IDLE: begin
                s_d.req = 1'b0;
                if (acc_req_in && !s_q.core_rst) begin
                    if (on_chip(acc_addr_in, s_q.mode)) begin
                        s_d.internal = 1'b1;
                        s_d.done     = 1'b1;
                    end else if (!expd) begin
                        s_d.err  = 1'b1;
                        s_d.done = 1'b1;
                    end else begin
                        s_d.addr  = acc_addr_in;
                        s_d.wdata = acc_wdata_in;
                        s_d.we    = acc_we_in;
                        s_d.bst   = CMR_B_REQ;
                        s_d.gnt   = s_q.gnt;
                    end
                end
            end
            CMR_B_REQ: begin
                if (IS_EXEC) begin
                    if (!s_q.gnt) begin
                        s_d.bst = CMR_B_ADDR;
                    end
                end else begin
                    s_d.req = 1'b1;
                    if (s_q.req && ctl(port_one_hi_in[`CMR_CTL_GNT])) begin
                        s_d.bst = CMR_B_ADDR;
                    end
                end
            end
            CMR_B_ADDR: begin
                s_d.bst = CMR_B_DATA;
            end
            CMR_B_DATA: begin
                if (ack) begin
                    s_d.rdata = parallel_port_zero_in;
                    s_d.done  = 1'b1;
                    s_d.req   = 1'b0;
                    s_d.bst   = CMR_B_IDLE;
                end
            end
            default: begin
                s_d.bst = CMR_B_IDLE;
            end
        endcase

        if (expd) begin
            // Port zero and the upper half of port one become the bus.
            s_d.p0_out  = (s_d.bst == CMR_B_ADDR) ? s_d.addr : s_d.wdata;
            s_d.p0_oe_n = ((s_d.bst == CMR_B_ADDR) ||
                           ((s_d.bst == CMR_B_DATA) && s_d.we)) ?
                          16'h0000 : 16'hFFFF;
            s_d.ready   = 2'b00;
            s_d.p1_out  = 8'h00;
            s_d.p1_oe_n = 8'hFF;
            s_d.p1_out[`CMR_CTL_ADDR_STB] = ctl((s_d.bst == CMR_B_ADDR) ||
                                                (s_d.bst == CMR_B_DATA));
            s_d.p1_out[`CMR_CTL_DATA_STB] = ctl(s_d.bst == CMR_B_DATA);
            s_d.p1_out[`CMR_CTL_READ]     = ~s_d.we;
            if ((s_d.bst == CMR_B_ADDR) || (s_d.bst == CMR_B_DATA)) begin
                s_d.p1_oe_n[`CMR_CTL_READ:`CMR_CTL_ADDR_STB] = 3'h0;
            end
            if (IS_EXEC) begin
                s_d.p1_out[`CMR_CTL_GNT]  = ctl(s_d.gnt);
                s_d.p1_oe_n[`CMR_CTL_GNT] = 1'b0;
            end else begin
                s_d.p1_out[`CMR_CTL_REQ]  = ctl(s_d.req);
                s_d.p1_oe_n[`CMR_CTL_REQ] = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst) begin
            s_q           <= '0;
            s_q.mst       <= CMR_M_HOLD;
            s_q.bst       <= CMR_B_IDLE;
            s_q.core_rst  <= 1'b1;
            s_q.nmi_prev  <= 1'b1;
            s_q.p0_oe_n   <= 16'hFFFF;
            s_q.p1_oe_n   <= 8'hFF;
        end else begin
            s_q <= s_d;
        end
    end

    assign core_reset_out              = s_q.core_rst;
    assign instruction_clock_out       = s_q.clk;
    assign bus_mode_out                = s_q.mode;
    assign nmi_take_out                = s_q.nmi_pend;
    assign irq_take_out                = s_q.irq_take;
    assign irq_vector_out              = s_q.irq_vec;
    assign gpio0_rd_out                = s_q.p0_rd;
    assign gpio1_hi_rd_out             = s_q.p1_rd;
    assign ready_out                   = s_q.ready;
    assign hs_data_out                 = s_q.hs_in;
    assign acc_done_out                = s_q.done;
    assign acc_internal_out            = s_q.internal;
    assign acc_err_out                 = s_q.err;
    assign acc_rdata_out               = s_q.rdata;
    assign parallel_port_zero_out      = s_q.p0_out;
    assign parallel_port_zero_oe_n_out = s_q.p0_oe_n;
    assign port_one_hi_out             = s_q.p1_out;
    assign port_one_hi_oe_n_out        = s_q.p1_oe_n;

endmodule

// ==== cmr_chk_asserts.sv ====
// Purpose: Port-level assertions for cmr_chip_config.
// Assumes: Default GP executive variant and default memory sizes.
// Notes:   Attached to the design by the bind at the foot.
`timescale 1ns/1ps
`include "cmr_params.svh"

module cmr_chk
    import cmr_pkg::*;
(
    input wire logic        sys_clk_in,
    input wire logic        sys_rst_in,
    input wire logic        chip_reset_n_in,
    input wire logic        nmi_n_in,
    input wire logic        level_one_irq_enable_in,
    input wire logic [15:0] gpio0_dir_in,
    input wire logic [3:0]  hs_mode_in,
    input wire logic        acc_req_in,
    input wire logic [15:0] acc_addr_in,
    input wire logic        core_reset_out,
    input wire logic        instruction_clock_out,
    input wire cmr_mode_t   bus_mode_out,
    input wire logic        nmi_take_out,
    input wire logic        irq_take_out,
    input wire logic        acc_done_out,
    input wire logic        acc_internal_out,
    input wire logic        acc_err_out,
    input wire logic [15:0] parallel_port_zero_out,
    input wire logic [15:0] parallel_port_zero_oe_n_out,
    input wire logic [7:0]  port_one_hi_out
);
    logic        busy_q;
    logic [15:0] addr_q;
    wire         rst  = sys_rst_in || !chip_reset_n_in;
    wire         take = acc_req_in && !busy_q && !core_reset_out;
    wire         offc = acc_addr_in >= 16'h1000 && acc_addr_in < 16'hFB00;

    // Tracks an accepted access until its completion pulse.
    always_ff @(posedge sys_clk_in) begin
        busy_q <= !rst && (take || (busy_q && !acc_done_out));
        addr_q <= take ? acc_addr_in : addr_q;
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst);

    reset_state_a: assert property (disable iff (1'b0) rst |=>
        core_reset_out && &parallel_port_zero_oe_n_out)
        else $error("reset state not restored");
    clk_half_a: assert property (!rst |=>
        instruction_clock_out != $past(instruction_clock_out))
        else $error("instruction clock did not toggle");
    nmi_fall_a: assert property ($fell(nmi_n_in) && !core_reset_out
        |=> nmi_take_out) else $error("nmi edge not taken");
    nmi_level_a: assert property (!nmi_take_out && !$fell(nmi_n_in)
        |=> !nmi_take_out) else $error("nmi taken without edge");
    nmi_prio_a: assert property (nmi_take_out && $past(nmi_take_out)
        |-> !irq_take_out) else $error("maskable beat nmi");
    irq_mask_a: assert property (!level_one_irq_enable_in
        |=> !irq_take_out) else $error("masked request taken");
    mode_hold_a: assert property (!core_reset_out &&
        !$past(core_reset_out) |-> $stable(bus_mode_out))
        else $error("mode changed without reset");
    local_acc_a: assert property (take && acc_addr_in >= 16'hFC00
        |=> acc_done_out && acc_internal_out && !acc_err_out)
        else $error("on-chip access not local");
    single_err_a: assert property (take && offc &&
        bus_mode_out == CMR_SINGLE |=> acc_done_out && acc_err_out)
        else $error("off-chip access in single mode");
    addr_phase_a: assert property (take && offc &&
        bus_mode_out != CMR_SINGLE |-> ##[1:4]
        (parallel_port_zero_oe_n_out == 16'h0000 &&
        parallel_port_zero_out == addr_q &&
        port_one_hi_out[`CMR_CTL_ADDR_STB]))
        else $error("address phase missing");
    gpio_dir_a: assert property (bus_mode_out == CMR_SINGLE &&
        !core_reset_out && !$past(core_reset_out) &&
        hs_mode_in == 4'h0 && $stable(hs_mode_in) &&
        $stable(gpio0_dir_in) |->
        parallel_port_zero_oe_n_out == ~gpio0_dir_in)
        else $error("port zero direction wrong");

    cover property (take && offc && bus_mode_out != CMR_SINGLE);
    cover property ($rose(nmi_take_out));
    cover property (acc_done_out && acc_err_out);
endmodule

bind cmr_chip_config cmr_chk u_chk (.*);

// ==== cmr_bus_partner.sv ====
// Purpose: External memory on the multiplexed bus, GP active-high control.
// Assumes: Device is executive; no other requester is present.
// Notes:   Released lines other than request, acknowledge and read data show a pattern that flips every cycle.
`timescale 1ns/1ps
`include "cmr_params.svh"

module cmr_bus_partner #(
    parameter int          ACK_DLY = 2,
    parameter logic [15:0] RD_DATA = 16'hC3A5
) (
    input  wire logic        clk_in,
    input  wire logic [15:0] p0_out_in,
    input  wire logic [15:0] p0_oe_n_in,
    input  wire logic [7:0]  p1_out_in,
    input  wire logic [7:0]  p1_oe_n_in,
    output logic      [15:0] p0_pin_out,
    output logic      [7:0]  p1_pin_out,
    output logic      [15:0] last_addr_out,
    output logic      [15:0] last_data_out
);
    logic [3:0]  cnt = 4'h0;
    logic        ack = 1'b0;
    logic        pat = 1'b0;
    logic [15:0] far0;
    logic [7:0]  far1;
    wire dstb = p1_out_in[`CMR_CTL_DATA_STB] && !p1_oe_n_in[`CMR_CTL_DATA_STB];
    wire astb = p1_out_in[`CMR_CTL_ADDR_STB] && !p1_oe_n_in[`CMR_CTL_ADDR_STB];
    wire rd   = p1_out_in[`CMR_CTL_READ];

    always_comb begin
        far0 = (dstb && rd) ? RD_DATA : {16{pat}};
        // Request line held low: nobody else asks for the bus.
        far1 = {{3{pat}}, 1'b0, ack, {3{pat}}};
        p0_pin_out = (p0_out_in & ~p0_oe_n_in) | (far0 & p0_oe_n_in);
        p1_pin_out = (p1_out_in & ~p1_oe_n_in) | (far1 & p1_oe_n_in);
    end

    always_ff @(posedge clk_in) begin
        pat <= ~pat;
        cnt <= dstb ? cnt + 4'h1 : 4'h0;
        ack <= dstb && (cnt >= 4'(ACK_DLY));
        if (astb && !dstb) begin
            last_addr_out <= p0_pin_out;
        end
        if (dstb && !rd) begin
            last_data_out <= p0_pin_out;
        end
    end
endmodule

// ==== cmr_tb.sv ====
// Purpose: Self-checking bench for cmr_chip_config.
// Assumes: Default parameters; partner answers external cycles.
// Notes:   Strap rows first, then hand-written cases.
`timescale 1ns/1ps

module testbench
    import cmr_pkg::*;
;
    typedef struct packed {
        logic [1:0] sel;
        cmr_mode_t  mode;
    } cmr_row_t;
    cmr_row_t rows [3] = '{'{2'h2, CMR_FULL}, '{2'h1, CMR_SINGLE},
                           '{2'h0, CMR_PARTIAL}};
    logic sys_clk_in = 1'b0, rst = 1'b1, crn = 1'b1, nmi_n = 1'b1;
    logic nack = 1'b0, l1e = 1'b0, areq = 1'b0, awe = 1'b0;
    logic [1:0] sel = 2'h1, hsw = 2'h0, hsr = 2'h0, stb = 2'h0;
    logic [3:0] hsm = 4'h0;
    logic [7:0] g1o = 8'h00, g1d = 8'h00;
    logic [15:0] irq = 16'h0, g0o = 16'h0, g0d = 16'h0;
    logic [15:0] aadr = 16'h0, awd = 16'h0, p0o, p0e, p0p, wa, wd, rdat;
    logic [7:0] p1o, p1e, p1p, g1r;
    logic [15:0] g0r, hsd, c16;
    logic [1:0] rdy;
    logic [3:0] vec;
    logic c_rst, iclk, nmi_t, irq_t, done, intl, err, c0;
    cmr_mode_t mode;
    int n_fail = 0, compares = 0;
    wire strap = sel[1] ? iclk : sel[0];

    always #4 sys_clk_in = ~sys_clk_in;

    cmr_chip_config uut (.sys_clk_in(sys_clk_in), .sys_rst_in(rst),
        .chip_reset_n_in(crn), .mode_strap_in(strap), .nmi_n_in(nmi_n),
        .nmi_ack_in(nack), .level_one_irq_enable_in(l1e), .irq_req_in(irq),
        .gpio0_out_in(g0o), .gpio0_dir_in(g0d), .gpio1_hi_out_in(g1o),
        .gpio1_hi_dir_in(g1d), .hs_mode_in(hsm), .hs_write_in(hsw),
        .hs_read_in(hsr), .strobe_in(stb), .acc_req_in(areq),
        .acc_we_in(awe), .acc_addr_in(aadr), .acc_wdata_in(awd),
        .parallel_port_zero_in(p0p), .port_one_hi_in(p1p[7:0]),
        .core_reset_out(c_rst), .instruction_clock_out(iclk),
        .bus_mode_out(mode), .nmi_take_out(nmi_t), .irq_take_out(irq_t),
        .irq_vector_out(vec), .gpio0_rd_out(g0r), .gpio1_hi_rd_out(g1r),
        .ready_out(rdy), .hs_data_out(hsd), .acc_done_out(done),
        .acc_internal_out(intl), .acc_err_out(err), .acc_rdata_out(rdat),
        .parallel_port_zero_out(p0o), .parallel_port_zero_oe_n_out(p0e),
        .port_one_hi_out(p1o), .port_one_hi_oe_n_out(p1e));

    cmr_bus_partner u_far (.clk_in(sys_clk_in), .p0_out_in(p0o),
        .p0_oe_n_in(p0e), .p1_out_in(p1o), .p1_oe_n_in(p1e),
        .p0_pin_out(p0p), .p1_pin_out(p1p), .last_addr_out(wa),
        .last_data_out(wd));

    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask

    task automatic do_rst(input logic [1:0] s);
        @(posedge sys_clk_in);
        rst <= 1'b1;
        sel <= s;
        cyc(2);
        chk("core_rst", 16'h1, 16'(c_rst));
        chk("p0_oe_n", 16'hFFFF, p0e);
        @(posedge sys_clk_in);
        rst <= 1'b0;
        cyc(4);
    endtask

    task automatic acc(input logic w, input logic [15:0] a,
                       input logic [15:0] d);
        int i;
        @(posedge sys_clk_in);
        areq <= 1'b1;
        awe <= w;
        aadr <= a;
        awd <= d;
        cyc(1);
        areq <= 1'b0;
        for (i = 0; i < 40 && done !== 1'b1; i++) begin
            cyc(1);
        end
        if (done !== 1'b1) begin
            n_fail++;
            end_sim();
        end
    endtask

    initial begin
        for (int r = 0; r < 3; r++) begin
            do_rst(rows[r].sel);
            chk("mode", 16'(rows[r].mode), 16'(mode));
            chk("core_run", 16'h0, 16'(c_rst));
            $display("strap row %0d done", r);
        end
        for (int k = 0; k < 4; k++) begin
            c0 = iclk;
            cyc(1);
            chk("instruction_clock_out", {15'h0, ~c0}, 16'(iclk));
        end
        sel <= 2'h1;
        g0d <= 16'hFFFF;
        cyc(6);
        chk("mode_held", 16'(CMR_PARTIAL), 16'(mode));
        chk("bus_idle", 16'hFFFF, p0e);
        acc(1'b1, 16'h8000, 16'h1234);
        chk("err", 16'h0, 16'(err));
        chk("wr_addr", 16'h8000, wa);
        chk("wr_data", 16'h1234, wd);
        acc(1'b0, 16'h8002, 16'h0);
        chk("rd_data", 16'hC3A5, rdat);
        acc(1'b0, 16'hFC02, 16'h0);
        chk("internal", 16'h1, 16'(intl));
        chk("no_ext", 16'h8002, wa);
        $display("bus test done");
        irq <= 16'h0010;
        cyc(2);
        chk("irq_mask", 16'h0, 16'(irq_t));
        nmi_n <= 1'b0;
        cyc(2);
        chk("nmi", 16'h1, 16'(nmi_t));
        chk("irq_nmi", 16'h0, 16'(irq_t));
        nack <= 1'b1;
        cyc(1);
        nack <= 1'b0;
        l1e <= 1'b1;
        cyc(3);
        chk("nmi_low", 16'h0, 16'(nmi_t));
        chk("irq", 16'h1, 16'(irq_t));
        chk("vec", 16'h4, 16'(vec));
        nmi_n <= 1'b1;
        cyc(1);
        nmi_n <= 1'b0;
        cyc(2);
        chk("nmi2", 16'h1, 16'(nmi_t));
        crn <= 1'b0;
        nmi_n <= 1'b1;
        cyc(2);
        chk("pin_rst", 16'h1, 16'(c_rst));
        chk("nmi_rst", 16'h0, 16'(nmi_t));
        crn <= 1'b1;
        cyc(4);
        $display("interrupt test done");
        do_rst(2'h1);
        g0d <= 16'h00FF;
        g0o <= 16'hA5A5;
        g1d <= 8'hFF;
        g1o <= 8'h3C;
        cyc(3);
        chk("gpio_oe", 16'hFF00, p0e);
        chk("gpio_out", 16'h00A5, p0o & 16'h00FF);
        chk("p1_oe", 16'h0000, 16'(p1e));
        chk("p1_out", 16'h003C, 16'(p1o));
        chk("gpio1_rd", 16'h003C, 16'(g1r));
        chk("gpio_rd", 16'h00A5, g0r & 16'h00FF);
        acc(1'b0, 16'h8000, 16'h0);
        chk("single_err", 16'h1, 16'(err));
        hsm <= 4'h2;
        hsw <= 2'h1;
        cyc(1);
        hsw <= 2'h0;
        cyc(2);
        chk("ready_full", 16'h1, 16'(rdy[0]));
        stb <= 2'h1;
        cyc(3);
        chk("ready_empty", 16'h0, 16'(rdy[0]));
        hsm <= 4'h1;
        cyc(2);
        chk("in_ready", 16'h1, 16'(rdy[0]));
        stb <= 2'h0;
        c16 = p0p;
        cyc(2);
        chk("hs_in", {8'h00, c16[7:0]}, hsd & 16'h00FF);
        chk("in_full", 16'h0, 16'(rdy[0]));
        hsm <= 4'h3;
        stb <= 2'h1;
        cyc(2);
        chk("bidir_oe", 16'h0000, p0e & 16'h00FF);
        $display("single test done");
        end_sim();
    end
endmodule
